// file: exec_pkg.sv
// Purpose: shared constants for the execute block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes:   one register per aligned word
package exec_pkg;
  localparam int ADDR_W = 12;
  // register map
  localparam logic [11:0] OFF_CMD    = 12'h000;
  localparam logic [11:0] OFF_IMM    = 12'h004;
  localparam logic [11:0] OFF_PC     = 12'h008;
  localparam logic [11:0] OFF_FLAGS  = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_SP     = 12'h014;
  localparam logic [11:0] OFF_REGS   = 12'h080;
  localparam logic [11:0] OFF_IO     = 12'h100;
  localparam logic [11:0] WIN_MASK   = 12'hf80;
  // command fields
  localparam int CMD_OP  = 0;
  localparam int CMD_RD  = 5;
  localparam int CMD_RR  = 10;
  localparam int CMD_BIT = 15;
  localparam int CMD_CY  = 18;
  localparam int CMD_IMM = 19;
  localparam int IMM_TWO = 16;
  // status_flags_register bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_I = 7;
  // cycle counts, response codes and stack depth
  localparam logic [2:0] CYC_ONE  = 3'h1;
  localparam logic [2:0] CYC_TWO  = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RET  = 3'h4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int STACK_DEPTH = 8;
  typedef enum logic [4:0] {
    op_sum, op_word_immediate_sum, op_difference,
    op_word_immediate_difference, op_and, op_or, op_xor,
    op_mask_set_bits, op_mask_clear_bits, op_relative_jump,
    op_pointer_jump, op_relative_call, op_pointer_call,
    op_return, op_interrupt_return, op_compare_skip_equal,
    op_compare, op_register_bit_skip_clear,
    op_register_bit_skip_set, op_io_bit_skip_clear,
    op_io_bit_skip_set, op_flag_branch_set, op_flag_branch_clear,
    op_io_bit_force_one, op_io_bit_force_zero,
    op_shift_left_logical, op_shift_right_logical,
    op_rotate_left_carry
  } op_e;
  typedef enum logic {st_idle = 1'b0, st_exec = 1'b1} state_e;
endpackage

// file: cpu_alu_branch_execute.sv
// Purpose: executes one alu, branch, skip or bit instruction per command
// Assumes: single clock, software loads operands over AXI4-Lite
// Notes:   state commits at the accepting edge, busy then shows the cycles
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cpu_alu_branch_execute (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic [exec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [exec_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import exec_pkg::*;

  logic [7:0]  regs [32];
  logic [7:0]  io_space [32];
  logic [15:0] ret_stack [STACK_DEPTH];
  logic [2:0]  sp;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [31:0] cmd;
  logic [16:0] imm;
  logic [2:0]  cnt;
  logic [2:0]  last_cyc;
  logic        last_taken;
  state_e      state;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        start;
  logic        idle;
  logic [31:0] mdata;

  // merges byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // half carry, overflow, carry of an 8-bit sum
  function automatic logic [2:0] add_hvc(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] r);
    return {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
            (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
            (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7])};
  endfunction

  // half borrow, overflow, borrow of an 8-bit difference
  function automatic logic [2:0] sub_hvc(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] r);
    return {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
            (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
            (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7])};
  endfunction

  // command fields come straight from the pending write data
  op_e        op;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [2:0] bsel;
  logic       with_c;
  logic [7:0] a;
  logic [7:0] b;
  logic [4:0] rd_lo;
  logic [4:0] rd_hi;
  logic [15:0] pair;
  logic [15:0] zptr;
  logic [15:0] rel_pc;
  logic [15:0] br_pc;
  logic [15:0] skip_pc;
  logic [2:0]  skip_cyc;
  logic [15:0] pop_pc;
  assign op      = op_e'(w_data[CMD_OP +: 5]);
  assign rd      = w_data[CMD_RD +: 5];
  assign rr      = w_data[CMD_RR +: 5];
  assign bsel    = w_data[CMD_BIT +: 3];
  assign with_c  = w_data[CMD_CY];
  assign a       = regs[rd];
  assign b       = w_data[CMD_IMM] ? imm[7:0] : regs[rr];
  assign rd_lo   = {rd[4:1], 1'b0};
  assign rd_hi   = {rd[4:1], 1'b1};
  assign pair    = {regs[rd_hi], regs[rd_lo]};
  assign zptr    = {regs[31], regs[30]};
  assign rel_pc  = pc + {{4{imm[11]}}, imm[11:0]} + 16'h1;
  assign br_pc   = pc + {{9{imm[6]}}, imm[6:0]} + 16'h1;
  // a skip passes over one or two program words
  assign skip_pc  = pc + (imm[IMM_TWO] ? 16'h3 : 16'h2);
  assign skip_cyc = imm[IMM_TWO] ? CYC_CALL : CYC_TWO;
  assign pop_pc  = ret_stack[sp - 3'h1];

  logic [7:0]  next_res;
  logic [7:0]  next_hi;
  logic        next_wr;
  logic        next_word;
  logic [7:0]  next_flags;
  logic [15:0] next_pc;
  logic [2:0]  next_cyc;
  logic        next_io_wr;
  logic [7:0]  next_io_val;
  logic        next_push;
  logic        next_pop;
  logic        next_taken;

  // instruction evaluation, committed only on start
  always_comb begin
    logic [8:0]  s9;
    logic [8:0]  d9;
    logic [15:0] w16;
    logic        cin;
    logic        cond;
    logic        alu;
    s9 = 9'h0;
    d9 = 9'h0;
    w16 = 16'h0;
    cin = with_c & flags[FL_C];
    cond = 1'b0;
    alu = 1'b1;
    next_res = 8'h0;
    next_hi = 8'h0;
    next_wr = 1'b0;
    next_word = 1'b0;
    next_flags = flags;
    next_pc = pc + 16'h1;
    next_cyc = CYC_ONE;
    next_io_wr = 1'b0;
    next_io_val = io_space[rr];
    next_push = 1'b0;
    next_pop = 1'b0;
    next_taken = 1'b0;
    case (op)
      op_sum: begin
        s9 = {1'b0, a} + {1'b0, b} + {8'h0, cin};
        next_res = s9[7:0];
        next_wr = 1'b1;
        {next_flags[FL_H], next_flags[FL_V], next_flags[FL_C]} =
          add_hvc(a, b, s9[7:0]);
        next_flags[FL_Z] = (s9[7:0] == 8'h0);
      end
      op_difference, op_compare: begin
        d9 = {1'b0, a} - {1'b0, b} - {8'h0, cin};
        next_res = d9[7:0];
        next_wr = (op == op_difference);
        {next_flags[FL_H], next_flags[FL_V], next_flags[FL_C]} =
          sub_hvc(a, b, d9[7:0]);
        // with carry, zero can only stay set across a chain
        next_flags[FL_Z] = (d9[7:0] == 8'h0) &
                           (with_c ? flags[FL_Z] : 1'b1);
      end
      op_word_immediate_sum, op_word_immediate_difference: begin
        if (op == op_word_immediate_sum) begin
          w16 = pair + {10'h0, imm[5:0]};
          next_flags[FL_V] = ~pair[15] & w16[15];
          next_flags[FL_C] = ~w16[15] & pair[15];
        end else begin
          w16 = pair - {10'h0, imm[5:0]};
          next_flags[FL_V] = pair[15] & ~w16[15];
          next_flags[FL_C] = w16[15] & ~pair[15];
        end
        {next_hi, next_res} = w16;
        next_wr = 1'b1;
        next_word = 1'b1;
        next_flags[FL_Z] = (w16 == 16'h0);
        next_flags[FL_N] = w16[15];
        next_cyc = CYC_TWO;
      end
      op_and, op_or, op_xor, op_mask_set_bits, op_mask_clear_bits: begin
        case (op)
          op_and:             next_res = a & b;
          op_or:              next_res = a | b;
          op_xor:             next_res = a ^ b;
          op_mask_set_bits:   next_res = a | imm[7:0];
          default:            next_res = a & (8'hff - imm[7:0]);
        endcase
        next_wr = 1'b1;
        next_flags[FL_V] = 1'b0;
        next_flags[FL_Z] = (next_res == 8'h0);
      end
      op_shift_left_logical, op_rotate_left_carry: begin
        cin = (op == op_rotate_left_carry) & flags[FL_C];
        next_res = {a[6:0], cin};
        next_wr = 1'b1;
        next_flags[FL_C] = a[7];
        next_flags[FL_Z] = (next_res == 8'h0);
        next_flags[FL_V] = next_res[7] ^ a[7];
      end
      op_shift_right_logical: begin
        next_res = {1'b0, a[7:1]};
        next_wr = 1'b1;
        next_flags[FL_C] = a[0];
        next_flags[FL_Z] = (next_res == 8'h0);
        next_flags[FL_V] = a[0];
      end
      op_relative_jump, op_pointer_jump, op_relative_call, op_pointer_call: begin
        alu = 1'b0;
        next_pc = (op == op_relative_jump || op == op_relative_call) ?
                  rel_pc : zptr;
        next_cyc = CYC_TWO;
        if (op == op_relative_call || op == op_pointer_call) begin
          next_push = 1'b1;
          next_cyc = CYC_CALL;
        end
      end
      op_return, op_interrupt_return: begin
        alu = 1'b0;
        next_pop = 1'b1;
        next_pc = pop_pc;
        next_cyc = CYC_RET;
        if (op == op_interrupt_return) begin
          next_flags[FL_I] = 1'b1;
        end
      end
      op_compare_skip_equal, op_register_bit_skip_clear,
      op_register_bit_skip_set, op_io_bit_skip_clear,
      op_io_bit_skip_set: begin
        alu = 1'b0;
        case (op)
          op_compare_skip_equal:      cond = (a == regs[rr]);
          op_register_bit_skip_clear: cond = ~regs[rr][bsel];
          op_register_bit_skip_set:   cond = regs[rr][bsel];
          op_io_bit_skip_clear:       cond = ~io_space[rr][bsel];
          default:                    cond = io_space[rr][bsel];
        endcase
        if (cond) begin
          next_pc = skip_pc;
          next_cyc = skip_cyc;
          next_taken = 1'b1;
        end
      end
      op_flag_branch_set, op_flag_branch_clear: begin
        alu = 1'b0;
        // the sign test is recomputed so it is always n xor v
        cond = (bsel == 3'(FL_S)) ? (flags[FL_N] ^ flags[FL_V]) :
               flags[bsel];
        if (cond == (op == op_flag_branch_set)) begin
          next_pc = br_pc;
          next_cyc = CYC_TWO;
          next_taken = 1'b1;
        end
      end
      op_io_bit_force_one, op_io_bit_force_zero: begin
        alu = 1'b0;
        next_io_wr = 1'b1;
        next_io_val[bsel] = (op == op_io_bit_force_one);
        next_cyc = CYC_TWO;
      end
      default: begin
        alu = 1'b0;
      end
    endcase
    if (alu && !next_word) begin
      next_flags[FL_N] = next_res[7];
    end
    // only the word ops touch the sign flag; the byte ops leave it as it was
    if (next_word) begin
      next_flags[FL_S] = next_flags[FL_N] ^ next_flags[FL_V];
    end
  end

  // bus write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign idle    = (state == st_idle);
  assign start   = wr_fire && idle && (aw_addr[11:2] == OFF_CMD[11:2]);

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; any write while busy is refused
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (idle && map_ok(aw_addr)) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // known addresses, used by both bus channels
  function automatic logic map_ok(input logic [11:0] ad);
    return (ad[11:2] <= OFF_SP[11:2]) ||
           ((ad & WIN_MASK) == OFF_REGS) || ((ad & WIN_MASK) == OFF_IO);
  endfunction

  logic bus_wr;
  assign bus_wr = wr_fire && idle;
  assign mdata = merge(32'h0, w_data, w_strb);

  // command, immediate and sequencer state
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd <= 32'h0;
      imm <= 17'h0;
      state <= st_idle;
      cnt <= 3'h0;
      last_cyc <= 3'h0;
      last_taken <= 1'b0;
    end else begin
      if (start) begin
        cmd <= merge(cmd, w_data, w_strb);
        state <= st_exec;
        cnt <= next_cyc;
        last_cyc <= next_cyc;
        last_taken <= next_taken;
      end else if (state == st_exec) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          state <= st_idle;
        end
      end
      if (bus_wr && aw_addr[11:2] == OFF_IMM[11:2]) begin
        imm <= 17'(merge({15'h0, imm}, w_data, w_strb));
      end
    end
  end

  // program counter, flags and return stack pointer
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc <= 16'h0;
      flags <= 8'h0;
      sp <= 3'h0;
    end else if (start) begin
      pc <= next_pc;
      flags <= next_flags;
      if (next_push) begin
        sp <= sp + 3'h1;
      end else if (next_pop) begin
        sp <= sp - 3'h1;
      end
    end else if (bus_wr) begin
      if (aw_addr[11:2] == OFF_PC[11:2]) begin
        pc <= 16'(merge({16'h0, pc}, w_data, w_strb));
      end
      if (aw_addr[11:2] == OFF_FLAGS[11:2]) begin
        flags <= 8'(merge({24'h0, flags}, w_data, w_strb));
      end
    end
  end

  // stack contents keep no reset, software never reads them
  always_ff @(posedge mclk) begin
    if (start && next_push) begin
      ret_stack[sp] <= pc + 16'h1;
    end
  end

  // working registers and io space
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 8'h0;
        io_space[i] <= 8'h0;
      end
    end else if (start) begin
      if (next_wr) begin
        regs[next_word ? rd_lo : rd] <= next_res;
      end
      if (next_word) begin
        regs[rd_hi] <= next_hi;
      end
      if (next_io_wr) begin
        io_space[rr] <= next_io_val;
      end
    end else if (bus_wr && w_strb[0]) begin
      if ((aw_addr & WIN_MASK) == OFF_REGS) begin
        regs[aw_addr[6:2]] <= mdata[7:0];
      end
      if ((aw_addr & WIN_MASK) == OFF_IO) begin
        io_space[aw_addr[6:2]] <= mdata[7:0];
      end
    end
  end

  // read channel, answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= map_ok(s_axi_araddr) ? RESP_OK : RESP_ERR;
      case (s_axi_araddr[11:2])
        OFF_CMD[11:2]:    s_axi_rdata <= cmd;
        OFF_IMM[11:2]:    s_axi_rdata <= {15'h0, imm};
        OFF_PC[11:2]:     s_axi_rdata <= {16'h0, pc};
        OFF_FLAGS[11:2]:  s_axi_rdata <= {24'h0, flags};
        OFF_STATUS[11:2]: s_axi_rdata <= {15'h0, last_taken, 5'h0,
                                          last_cyc, 7'h0, !idle};
        OFF_SP[11:2]:     s_axi_rdata <= {29'h0, sp};
        default: begin
          if ((s_axi_araddr & WIN_MASK) == OFF_REGS) begin
            s_axi_rdata <= {24'h0, regs[s_axi_araddr[6:2]]};
          end else if ((s_axi_araddr & WIN_MASK) == OFF_IO) begin
            s_axi_rdata <= {24'h0, io_space[s_axi_araddr[6:2]]};
          end else begin
            s_axi_rdata <= 32'h0;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on committed results and busy length
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic busy;
  assign busy = !idle;

  AST_SUM_ONE: assert property (
    start && op == op_sum |=> busy ##1 !busy)
    else $error("sum not one cycle");
  AST_SUM_CARRY: assert property (
    start && op == op_sum && !w_data[CMD_IMM] |=>
    flags[FL_C] == $past((({1'b0, a} + {1'b0, b} +
      {8'h0, with_c & flags[FL_C]}) >> 8) != 9'h0))
    else $error("sum carry wrong");
  AST_WORD_TWO: assert property (
    start && op == op_word_immediate_sum |=> busy[*2] ##1 !busy)
    else $error("word op not two cycles");
  AST_DIFF_STORE: assert property (
    start && op == op_difference && !with_c |=>
    regs[$past(rd)] == $past(a - b))
    else $error("difference not stored");
  AST_LOGIC_V: assert property (
    start && op == op_xor |=> !flags[FL_V] &&
    flags[FL_C] == $past(flags[FL_C]) && flags[FL_S] == $past(flags[FL_S]))
    else $error("logic op flags wrong");
  AST_MASK_CLEAR: assert property (
    start && op == op_mask_clear_bits |=>
    regs[$past(rd)] == ($past(a) & ~$past(imm[7:0])))
    else $error("clear bits wrong");
  AST_JUMP: assert property (
    start && op == op_relative_jump |=>
    pc == $past(rel_pc) && flags == $past(flags) ##0 busy[*2] ##1 !busy)
    else $error("jump wrong");
  AST_CALL: assert property (
    start && op == op_pointer_call |=>
    sp == $past(sp) + 3'h1 && pc == $past(zptr) ##0 busy[*3] ##1 !busy)
    else $error("call wrong");
  AST_SKIP: assert property (
    start && op == op_compare_skip_equal && a == regs[rr] |=>
    pc == $past(pc) + ($past(imm[IMM_TWO]) ? 16'h3 : 16'h2))
    else $error("skip distance wrong");
  AST_CMP_KEEP: assert property (
    start && op == op_compare |=> regs[$past(rd)] == $past(a))
    else $error("compare stored result");
  AST_SIGNED: assert property (
    start && op == op_flag_branch_clear && bsel == 3'(FL_S) &&
    (flags[FL_N] == flags[FL_V]) |=> pc == $past(br_pc))
    else $error("signed branch wrong");
  AST_INTERRUPT_RETURN: assert property (
    start && op == op_interrupt_return |=> flags[FL_I] ##0
    busy[*4] ##1 !busy)
    else $error("return wrong");
  CVR_SUM: cover property (start && op == op_sum);
  CVR_CALL_RET: cover property (start && op == op_relative_call
    ##[1:20] start && op == op_return);
  CVR_SKIP3: cover property (start && next_taken && next_cyc == CYC_CALL);
  CVR_BRANCH: cover property (start && op == op_flag_branch_set && next_taken);
endmodule

// file: cpu_alu_branch_execute_tb_top.sv
// Purpose: self-checking bench for the execute block over AXI4-Lite
// Assumes: 25 MHz mclk, srst synchronous and active high
// Notes:   expectations are rebuilt by bench functions, never read from the design
`timescale 1ns/1ns
module cpu_alu_branch_execute_tb_top;
  import exec_pkg::*;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
  logic        awr, wrd, bv, arr, rv;
  logic [1:0]  br, rr, lr;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h0000e200;
  int          n_fail = 0;
  int          tests_run = 0;
  // free-running clock, 40 ns period
  always #20 mclk = ~mclk;
  cpu_alu_branch_execute u_cpu_alu_branch_execute (
    .mclk(mclk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rq));
  // repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // command word: op, dest, source, bit select, immediate source
  function automatic logic [31:0] cm(logic [4:0] op, logic [4:0] d, logic [4:0] s,
                                     logic [2:0] b, logic im);
    return {12'h000, im, 1'b0, b, s, d, op};
  endfunction
  // word address inside a register window
  function automatic logic [11:0] ad(logic [11:0] base, logic [4:0] i);
    return base | {5'h00, i, 2'h0};
  endfunction
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // aw and w offered together, each dropped once its own ready is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (awr && !ta) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wrd && !tw) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge mclk);
    r = br;
    bq <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge mclk);
    d = rdat;
    lr = rr;
    rq <= 1'b0;
  endtask
  // run one instruction, wait out busy, compare the cycle count it reports
  task automatic ex(input logic [31:0] c, input logic [16:0] im, input logic [2:0] n);
    logic [31:0] s;
    logic [1:0]  r;
    wr(OFF_IMM, {15'h0, im}, r);
    wr(OFF_CMD, c, r);
    ck("cmd resp", {30'h0, RESP_OK}, {30'h0, r});
    s = 32'h1;
    for (int k = 0; k < 9 && s[0] !== 1'b0; k++) rd(OFF_STATUS, s);
    ck("idle", 32'h0, {31'h0, s[0]});
    ck("cycles", {29'h0, n}, {29'h0, s[10:8]});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // the run needs several hundred cycles; a hang costs a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
  // main sequence; first loop pass is the ff plus 01 carry-out corner case
  initial begin
    logic [31:0] a, b, v, p, x;
    logic [1:0]  r;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(OFF_PC, p);
    ck("pc reset", 32'h0, p);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 32'hff : xs() & 32'hff;
      b = (i == 0) ? 32'h01 : xs() & 32'hff;
      wr(ad(OFF_REGS, 1), a, r);
      wr(ad(OFF_REGS, 2), b, r);
      wr(OFF_FLAGS, 32'h0, r);
      ex(cm(op_sum, 1, 2, 0, 0), 0, CYC_ONE);
      v = a + b;
      rd(ad(OFF_REGS, 1), p);
      ck("sum", v & 32'hff, p);
      rd(OFF_FLAGS, p);
      ck("sum c z", {30'h0, v[7:0] == 8'h00, v[8]}, {30'h0, p[FL_Z], p[FL_C]});
      wr(ad(OFF_REGS, 1), a, r);
      ex(cm(op_difference, 1, 0, 0, 1), b[16:0], CYC_ONE);
      rd(ad(OFF_REGS, 1), p);
      ck("difference", (a - b) & 32'hff, p);
      rd(OFF_FLAGS, p);
      ck("borrow", {31'h0, a < b}, {31'h0, p[FL_C]});
      ex(cm(op_mask_clear_bits, 2, 0, 0, 1), a[16:0], CYC_ONE);
      v = b & ~a & 32'hff;
      rd(ad(OFF_REGS, 2), p);
      ck("mask clear", v, p);
      wr(OFF_FLAGS, 32'h1, r);
      ex(cm(op_rotate_left_carry, 2, 0, 0, 0), 0, CYC_ONE);
      rd(ad(OFF_REGS, 2), p);
      ck("rotate", ((v << 1) | 32'h1) & 32'hff, p);
      rd(OFF_FLAGS, p);
      ck("rotate carry", {31'h0, v[7]}, {31'h0, p[FL_C]});
      v = ((v << 1) | 32'h1) & 32'hff;
      x = ((a - b) ^ v) & 32'hff;
      ex(cm(op_xor, 1, 2, 0, 0), 0, CYC_ONE);
      rd(OFF_FLAGS, p);
      ck("xor s v n z", {28'h0, 2'b00, x[7], x == 32'h0}, {28'h0, p[4:1]});
      ex(cm(op_compare, 1, 2, 0, 0), 0, CYC_ONE);
      rd(ad(OFF_REGS, 1), p);
      ck("compare keeps", x, p);
      rd(OFF_FLAGS, p);
      ck("compare c z", {30'h0, x == v, x < v}, {30'h0, p[FL_Z], p[FL_C]});
    end
    wr(OFF_PC, 32'h100, r);
    ex(cm(op_relative_jump, 0, 0, 0, 0), 17'h00ff0, CYC_TWO);
    rd(OFF_PC, p);
    ck("jump back", 32'h0f1, p);
    ex(cm(op_relative_call, 0, 0, 0, 0), 17'h00010, CYC_CALL);
    rd(OFF_PC, p);
    ck("call", 32'h102, p);
    ex(cm(op_interrupt_return, 0, 0, 0, 0), 0, CYC_RET);
    rd(OFF_PC, p);
    ck("return", 32'h0f2, p);
    rd(OFF_FLAGS, p);
    ck("int enable", 32'h1, {31'h0, p[FL_I]});
    ex(cm(op_compare_skip_equal, 3, 4, 0, 0), 17'h10000, CYC_CALL);
    rd(OFF_PC, p);
    ck("skip two words", 32'h0f5, p);
    wr(OFF_FLAGS, 32'h04, r);
    ex(cm(op_flag_branch_set, 0, 0, 4, 0), 17'h00005, CYC_TWO);
    rd(OFF_PC, p);
    ck("less than taken", 32'h0fb, p);
    ex(cm(op_flag_branch_clear, 0, 0, 4, 0), 17'h00005, CYC_ONE);
    rd(OFF_PC, p);
    ck("greater equal not taken", 32'h0fc, p);
    ex(cm(op_io_bit_force_one, 0, 5, 3, 0), 0, CYC_TWO);
    rd(ad(OFF_IO, 5), p);
    ck("io bit one", 32'h08, p);
    wr(ad(OFF_REGS, 24), 32'hff, r);
    wr(ad(OFF_REGS, 25), 32'h7f, r);
    ex(cm(op_word_immediate_sum, 24, 0, 0, 0), 17'h00001, CYC_TWO);
    rd(ad(OFF_REGS, 25), p);
    ck("word sum high", 32'h80, p);
    rd(OFF_FLAGS, p);
    ck("word sum s v n z c", 32'h0c, {27'h0, p[4:0]});
    wr(ad(OFF_REGS, 30), 32'h34, r);
    wr(ad(OFF_REGS, 31), 32'h12, r);
    ex(cm(op_pointer_call, 0, 0, 0, 0), 0, CYC_CALL);
    rd(OFF_PC, p);
    ck("pointer call", 32'h1234, p);
    rd(OFF_SP, p);
    ck("stack depth", 32'h1, p);
    wr(OFF_FLAGS, 32'h0, r);
    ex(cm(op_flag_branch_clear, 0, 0, 4, 0), 17'h00005, CYC_TWO);
    rd(OFF_PC, p);
    ck("greater equal taken", 32'h123a, p);
    wr(OFF_FLAGS, 32'h40, r);
    ex(cm(op_flag_branch_set, 0, 0, 6, 0), 17'h00002, CYC_TWO);
    rd(OFF_PC, p);
    ck("transfer flag taken", 32'h123d, p);
    rd(12'h040, p);
    ck("unmapped resp", {30'h0, RESP_ERR}, {30'h0, lr});
    print_verdict();
  end
endmodule
